//--- hdl/flm_cal_mem.sv
// Calibration memory with registered read data.
`timescale 1ns/10ps
`default_nettype none
module flm_cal_mem
  import flm_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      write_enable,
  input  wire logic [CAL_ADDR_WIDTH-1:0] write_addr,
  input  wire logic [CAL_WIDTH-1:0]      write_data,
  input  wire logic [CAL_ADDR_WIDTH-1:0] read_addr,
  output var  logic [CAL_WIDTH-1:0]      read_data
);
  logic [CAL_WIDTH-1:0] mem [CAL_WORDS];

  always_ff @(posedge clock) begin
    if (write_enable) begin
      mem[write_addr] <= write_data;
    end
  end

  always_ff @(posedge clock) begin
    read_data <= mem[read_addr];
  end
endmodule // flm_cal_mem
`default_nettype wire

//--- hdl/flm_fault_monitor.sv
// Fault detectors, fault latch and self-test status logic.
`timescale 1ns/10ps
`default_nettype none
module flm_fault_monitor
  import flm_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic                      self_test_input,
  input  wire logic                      supply_undervoltage_detect,
  input  wire logic                      osc_clock,
  input  wire logic                      cal_write_enable,
  input  wire logic [CAL_ADDR_WIDTH-1:0] cal_write_addr,
  input  wire logic [CAL_WIDTH-1:0]      cal_write_data,
  output var  logic                      status,
  output var  logic                      self_test_drive,
  output var  flm_fault_s                fault_now,
  output var  logic                      fault_latch
);
  logic [1:0]               st_sync;
  logic                     st_prev;
  logic [1:0]               uv_sync;
  logic [1:0]               osc_sync;
  logic                     osc_prev;
  logic [OSC_CNT_WIDTH-1:0] osc_count;
  logic                     clock_fail;
  flm_scan_e                scan_state;
  logic [CAL_ADDR_WIDTH-1:0] scan_addr;
  logic [CAL_WIDTH-1:0]     cal_data;
  logic                     parity_acc;
  logic                     parity_odd;
  logic                     st_rise;
  logic                     any_fault;

  // Pin inputs pass two flops; only the second stage is read.
  always_ff @(posedge clock) begin
    if (reset) begin
      st_sync  <= 2'h0;
      st_prev  <= 1'b0;
      uv_sync  <= 2'h0;
      osc_sync <= 2'h0;
      osc_prev <= 1'b0;
    end else begin
      st_sync  <= {st_sync[0], self_test_input};
      st_prev  <= st_sync[1];
      uv_sync  <= {uv_sync[0], supply_undervoltage_detect};
      osc_sync <= {osc_sync[0], osc_clock};
      osc_prev <= osc_sync[1];
    end
  end

  assign st_rise = st_sync[1] & ~st_prev;

  // A missing toggle for longer than half a threshold period means a slow oscillator.
  always_ff @(posedge clock) begin
    if (reset) begin
      osc_count  <= OSC_CNT_RESET;
      clock_fail <= 1'b0;
    end else if (osc_sync[1] != osc_prev) begin
      osc_count  <= OSC_CNT_RESET;
      clock_fail <= 1'b0;
    end else if (osc_count >= OSC_LIMIT) begin
      clock_fail <= 1'b1;
    end else begin
      osc_count <= osc_count + 10'h001;
    end
  end

  flm_cal_mem u_cal_mem (
    .clock        (clock),
    .write_enable (cal_write_enable),
    .write_addr   (cal_write_addr),
    .write_data   (cal_write_data),
    .read_addr    (scan_addr),
    .read_data    (cal_data)
  );

  // Continuous parity scan; the result updates once per full pass.
  // The memory has no reset, so parity is unknown until every word has been written once.
  always_ff @(posedge clock) begin
    if (reset) begin
      scan_state <= FLM_SCAN_READ;
      scan_addr  <= CAL_ADDR_RESET;
      parity_acc <= 1'b0;
      parity_odd <= 1'b0;
    end else begin
      unique case (scan_state)
        FLM_SCAN_READ: begin
          scan_state <= FLM_SCAN_ACCUM;
        end
        FLM_SCAN_ACCUM: begin
          parity_acc <= parity_acc ^ (^cal_data);
          if (scan_addr == CAL_ADDR_LAST) begin
            scan_state <= FLM_SCAN_DONE;
          end else begin
            scan_addr  <= scan_addr + 4'h1;
            scan_state <= FLM_SCAN_READ;
          end
        end
        FLM_SCAN_DONE: begin
          parity_odd <= parity_acc;
          parity_acc <= 1'b0;
          scan_addr  <= CAL_ADDR_RESET;
          scan_state <= FLM_SCAN_READ;
        end
        default: begin
          scan_state <= FLM_SCAN_READ;
        end
      endcase
    end
  end

  assign any_fault = uv_sync[1] | clock_fail | parity_odd;

  // Fault set wins over the self-test clear edge.
  always_ff @(posedge clock) begin
    if (reset) begin
      fault_latch <= 1'b0;
      fault_now   <= '0;
    end else begin
      fault_now <= '{undervoltage: uv_sync[1], clock_fail: clock_fail, parity_odd: parity_odd};
      if (any_fault) begin
        fault_latch <= 1'b1;
      end else if (st_rise) begin
        fault_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      status          <= 1'b0;
      self_test_drive <= 1'b0;
    end else begin
      status          <= fault_latch | st_sync[1];
      self_test_drive <= st_sync[1];
    end
  end

  // Saturating count of cycles since the last oscillator toggle, read only by the checks.
  int unsigned stuck_cycles;
  always_ff @(posedge clock) begin
    if (reset || osc_sync[1] != osc_prev) begin
      stuck_cycles <= 0;
    end else if (stuck_cycles < 1000) begin
      stuck_cycles <= stuck_cycles + 1;
    end
  end

  status_or_a: assert property (@(posedge clock) disable iff (reset)
    ##1 status == ($past(fault_latch) | $past(st_sync[1])))
    else $error("status is not latch OR self-test");
  uv_sets_a: assert property (@(posedge clock) disable iff (reset)
    uv_sync[1] |=> fault_latch)
    else $error("undervoltage did not set latch");
  clk_fail_a: assert property (@(posedge clock) disable iff (reset)
    stuck_cycles > OSC_TIMEOUT_CYC + 2 |-> clock_fail)
    else $error("stopped oscillator not flagged");
  clk_ok_a: assert property (@(posedge clock) disable iff (reset)
    clock_fail |-> stuck_cycles >= OSC_TIMEOUT_CYC)
    else $error("clock fail flagged too early");
  parity_sets_a: assert property (@(posedge clock) disable iff (reset)
    parity_odd |=> fault_latch)
    else $error("odd parity did not set latch");
  clear_edge_a: assert property (@(posedge clock) disable iff (reset)
    fault_latch && !any_fault && st_rise |=> !fault_latch)
    else $error("rising edge did not clear latch");
  latch_hold_a: assert property (@(posedge clock) disable iff (reset)
    fault_latch && !st_rise |=> fault_latch)
    else $error("latch dropped without clear edge");
  stim_follow_a: assert property (@(posedge clock) disable iff (reset)
    $rose(st_sync[1]) |=> self_test_drive ##1 status)
    else $error("self-test stimulus not applied");
  edge_sync_a: assert property (@(posedge clock) disable iff (reset)
    st_rise |-> $past(self_test_input, 2) && !$past(self_test_input, 3))
    else $error("edge not from synchronised samples");
  power_clear_a: assert property (@(posedge clock) disable iff (reset)
    st_rise && !any_fault |=> ##1 ((status == $past(st_sync[1])) || $past(any_fault)))
    else $error("status not valid after first edge");

  // The parity bit is left out of the per-cycle report checks, since it is unknown until the
  // memory has been filled once.
  uv_now_a: assert property (@(posedge clock) disable iff (reset)
    ##1 fault_now.undervoltage == $past(uv_sync[1]))
    else $error("undervoltage report does not follow detector");
  clk_now_a: assert property (@(posedge clock) disable iff (reset)
    ##1 fault_now.clock_fail == $past(clock_fail))
    else $error("clock fail report does not follow monitor");
  drive_follow_a: assert property (@(posedge clock) disable iff (reset)
    ##1 self_test_drive == $past(st_sync[1]))
    else $error("stimulus enable does not follow self-test");
  set_wins_a: assert property (@(posedge clock) disable iff (reset)
    any_fault && st_rise |=> fault_latch)
    else $error("clear edge dropped latch during fault");
  clk_sets_a: assert property (@(posedge clock) disable iff (reset)
    clock_fail |=> fault_latch)
    else $error("clock fail did not set latch");
  latch_status_a: assert property (@(posedge clock) disable iff (reset)
    fault_latch |=> status)
    else $error("status low while latch set");
  st_status_a: assert property (@(posedge clock) disable iff (reset)
    st_sync[1] |=> status)
    else $error("status low while self-test high");
  clk_clear_a: assert property (@(posedge clock) disable iff (reset)
    osc_sync[1] != osc_prev |=> !clock_fail)
    else $error("clock fail kept after oscillator toggle");
  count_cap_a: assert property (@(posedge clock) disable iff (reset)
    osc_count <= OSC_LIMIT)
    else $error("oscillator count passed its limit");
  scan_end_a: assert property (@(posedge clock) disable iff (reset)
    scan_state == FLM_SCAN_DONE |-> scan_addr == CAL_ADDR_LAST)
    else $error("parity pass ended before last word");
  addr_step_a: assert property (@(posedge clock) disable iff (reset)
    scan_state == FLM_SCAN_ACCUM && scan_addr != CAL_ADDR_LAST |=> scan_addr == $past(scan_addr) + 4'h1)
    else $error("parity scan skipped a word");
  read_step_a: assert property (@(posedge clock) disable iff (reset)
    scan_state == FLM_SCAN_READ |=> scan_state == FLM_SCAN_ACCUM)
    else $error("parity scan did not accumulate after read");
  edge_once_a: assert property (@(posedge clock) disable iff (reset)
    st_rise |=> !st_rise)
    else $error("one self-test edge seen twice");

  uv_trip_c: cover property (@(posedge clock) disable iff (reset) $rose(uv_sync[1]));
  clk_trip_c: cover property (@(posedge clock) disable iff (reset) $rose(clock_fail));
  par_trip_c: cover property (@(posedge clock) disable iff (reset) $rose(parity_odd));
  clear_c: cover property (@(posedge clock) disable iff (reset) $fell(fault_latch));
  refused_clear_c: cover property (@(posedge clock) disable iff (reset) any_fault && st_rise);
endmodule // flm_fault_monitor
`default_nettype wire

//--- hdl/flm_pkg.sv
// Package of constants and carrier types for the fault latch status monitor.
// Contract
// - The status output is the OR of the fault latch and the current self-test input level.
// - A supply undervoltage report sets the fault latch.
// - An oscillator frequency below the minimum sets the fault latch.
// - Odd parity over the calibration memory bits sets the fault latch.
// - A self-test rising edge clears the latch unless a fault is still present then.
// - While self-test is held high the calibrated self-test stimulus is active.
// - Any one or several faults set the latch, which holds until a qualifying clear edge.
// - Status is undefined after power-up until the host applies one self-test rising edge.
// - The clock monitor flags failure below a threshold between 150 kHz and 400 kHz.
package flm_pkg;
  localparam int unsigned CAL_WORDS         = 16;
  localparam int unsigned CAL_WIDTH         = 8;
  localparam int unsigned CAL_ADDR_WIDTH    = 4;
  localparam int unsigned CLOCK_KHZ         = 250000;
  localparam int unsigned OSC_MIN_KHZ       = 150;
  localparam int unsigned OSC_MAX_KHZ       = 400;
  localparam int unsigned OSC_THRESHOLD_KHZ = 275;
  // A healthy oscillator toggles at least once per this many system cycles.
  localparam int unsigned OSC_TIMEOUT_CYC   = CLOCK_KHZ / (2 * OSC_THRESHOLD_KHZ);
  localparam int unsigned OSC_CNT_WIDTH     = 10;
  localparam logic [OSC_CNT_WIDTH-1:0] OSC_LIMIT = 10'(OSC_TIMEOUT_CYC);
  localparam logic [OSC_CNT_WIDTH-1:0] OSC_CNT_RESET = 10'h000;
  localparam logic [CAL_ADDR_WIDTH-1:0] CAL_ADDR_RESET = 4'h0;
  localparam logic [CAL_ADDR_WIDTH-1:0] CAL_ADDR_LAST  = 4'(CAL_WORDS - 1);

  typedef enum logic [1:0] {
    FLM_SCAN_READ  = 2'b00,
    FLM_SCAN_ACCUM = 2'b01,
    FLM_SCAN_DONE  = 2'b11
  } flm_scan_e;

  typedef struct packed {
    logic undervoltage;
    logic clock_fail;
    logic parity_odd;
  } flm_fault_s;
endpackage : flm_pkg

//--- test/flm_fault_monitor_tb.sv
// Self-checking testbench for the fault latch status monitor.
`timescale 1ns/10ps
`default_nettype none
module flm_fault_monitor_tb import flm_pkg::*; ;
  logic clock = 0, reset = 1, start = 0, uv = 0, osc = 0, osc_run = 1;
  logic we = 0, probe = 0, par, st, status, st_drive, latch;
  logic [CAL_ADDR_WIDTH-1:0] wa = '0;
  logic [CAL_WIDTH-1:0]      wd = '0;
  logic [CAL_WIDTH-1:0]      cal [CAL_WORDS];
  logic [5:0]                exp_q [$];
  logic [5:0]                e;
  flm_fault_s                fnow;
  int n_errors = 0, check_count = 0;

  flm_host host (.clock(clock), .start(start), .self_test_input(st));
  flm_fault_monitor uut (
    .clock(clock), .reset(reset), .self_test_input(st),
    .supply_undervoltage_detect(uv), .osc_clock(osc),
    .cal_write_enable(we), .cal_write_addr(wa), .cal_write_data(wd),
    .status(status), .self_test_drive(st_drive), .fault_now(fnow), .fault_latch(latch));

  initial begin
    forever #2 clock = ~clock;
  end
  // A healthy oscillator toggles far inside the monitor's timeout.
  initial begin
    forever begin
      repeat (100) @(posedge clock);
      #1 osc = osc ^ osc_run;
    end
  end
  // Outputs are compared as {status, self_test_drive, fault_latch, fault_now}.
  always @(posedge clock) begin
    if (probe) begin
      e = exp_q.pop_front();
      check_count++;
      if ({status, st_drive, latch, fnow} !== e) begin
        n_errors++;
        $display("[FAIL] outputs expected %b seen %b", e, {status, st_drive, latch, fnow});
      end
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [5:0] x);
    exp_q.push_back(x);
    probe = 1;
    tick(1);
    probe = 0;
    tick(1);
  endtask
  task automatic pulse;
    start = 1;
    tick(1);
    start = 0;
    tick(14);
  endtask
  task automatic wr(input int a, input logic [CAL_WIDTH-1:0] d);
    we = 1;
    wa = a[CAL_ADDR_WIDTH-1:0];
    wd = d;
    tick(1);
    we = 0;
    tick(1);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Gives up after a bounded wait so a missing latch cannot hang the run.
  task automatic wait_latch(input int lim);
    int i;
    for (i = 0; i < lim && latch !== 1'b1; i++) tick(1);
    if (i == lim) begin
      n_errors++;
      $display("[FAIL] latch wait expected 1 seen %b", latch);
      give_verdict();
    end else begin
      tick(2);
    end
  endtask

  initial begin
    void'($urandom(32'h4ba83a0b));
    tick(2);
    reset = 0;
    par = 0;
    foreach (cal[i]) cal[i] = 8'($urandom);
    foreach (cal[i]) par ^= ^cal[i];
    cal[0][0] = cal[0][0] ^ par;
    foreach (cal[i]) wr(i, cal[i]);
    tick(80);
    start = 1;
    tick(1);
    start = 0;
    tick(5);
    chk(6'b110000);
    tick(12);
    chk(6'b000000);
    uv = 1;
    wait_latch(10);
    chk(6'b101100);
    pulse();
    chk(6'b101100);
    uv = 0;
    tick(20);
    chk(6'b101000);
    pulse();
    chk(6'b000000);
    wr(0, cal[0] ^ 8'h01);
    wait_latch(100);
    chk(6'b101001);
    wr(0, cal[0]);
    tick(80);
    pulse();
    chk(6'b000000);
    osc_run = 0;
    wait_latch(1000);
    chk(6'b101010);
    osc_run = 1;
    tick(300);
    pulse();
    chk(6'b000000);
    give_verdict();
  end
endmodule // flm_fault_monitor_tb
`default_nettype wire

//--- test/flm_host.sv
// Host model that pulses the self-test pin on request.
`timescale 1ns/10ps
`default_nettype none
module flm_host #(
  parameter int HOLD = 8
) (
  input  wire logic clock,
  input  wire logic start,
  output var  logic self_test_input
);
  int cnt = 0;
  // The pin is driven low once the hold count reaches zero, so it idles low between pulses.
  always_ff @(posedge clock) begin
    if (start) begin
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign self_test_input = (cnt > 0);
endmodule // flm_host
`default_nettype wire
